/* owcs_pkg.sv */
// owcs_pkg: constants, register map, commands and carrier types of the
// ook wakeup call sequencer. assumes a single 100 MHz clock domain.
//
// How it works
// - call gates carrier on and off at 96kHz
// - timed call length from 0x04 bits 1:0
// - hold bit 0x04[5] keeps call going
// - 250us detect window once per listen period
// - call command starts timed or held call
// - detection stays open while pattern is present
// - leave on pattern low or three periods
// - alert flag only when pattern stopped
// - after call receiver listens for one second
// - listen hold bit 0x03[6] keeps window open
// - timer communication suspended while window open
// - random client packets accepted from several clients
// - packet: preamble, id, timing, length, payload, crc
// - each received packet with good crc answered by automatic ack
// - mask 0x2C[5] keeps alert off interrupt line
// - 0x00[2] places client in detection mode
package owcs_pkg;
  // clock and timing figures
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned OOK_RATE_HZ    = 96_000;
  localparam int unsigned OOK_HALF_CYC   = CLK_HZ / (2 * OOK_RATE_HZ);
  localparam int unsigned CALL_BASE_MS   = 125;
  localparam int unsigned CALL_BASE_CYC  = (CLK_HZ / 1000) * CALL_BASE_MS;
  localparam int unsigned LISTEN_WIN_US  = 250;
  localparam int unsigned LISTEN_WIN_CYC = (CLK_HZ / 1_000_000) * LISTEN_WIN_US;
  localparam int unsigned LISTEN_BASE_MS = 16;
  localparam int unsigned LISTEN_BASE_CYC = (CLK_HZ / 1000) * LISTEN_BASE_MS;
  localparam int unsigned FSK_WIN_MS     = 1000;
  localparam int unsigned FSK_WIN_CYC    = (CLK_HZ / 1000) * FSK_WIN_MS;
  localparam int unsigned ACT_PERIODS    = 3;
  // register offsets
  localparam logic [7:0] ADDR_MODE_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_SCAN_CTRL   = 8'h03;
  localparam logic [7:0] ADDR_WAKE_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_EVT_STATUS  = 8'h2A;
  localparam logic [7:0] ADDR_EVT_MASK    = 8'h2C;
  localparam logic [7:0] ADDR_PAY_LEN     = 8'h37;
  localparam logic [7:0] ADDR_PAY_FIRST   = 8'h38;
  localparam logic [7:0] ADDR_PAY_LAST    = 8'h51;
  localparam logic [7:0] ADDR_RX_COUNT    = 8'h52;
  localparam int unsigned PAY_DEPTH       = 26;
  // field positions
  localparam int unsigned BIT_LISTEN_EN   = 2;
  localparam int unsigned BIT_LISTEN_HOLD = 6;
  localparam int unsigned BIT_CALL_HOLD   = 5;
  localparam int unsigned BIT_ALERT       = 5;
  localparam int unsigned LSB_LISTEN_SEL  = 2;
  // reset values and packet constants
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [7:0] PREAMBLE_BYTE = 8'hAA;

  typedef enum logic [1:0] {OWCS_CMD_CALL, OWCS_CMD_LISTEN, OWCS_CMD_TRANSMIT, OWCS_CMD_NONE} owcs_cmd_code_type;
  typedef enum logic [1:0] {OWCS_M_IDLE, OWCS_M_CALL, OWCS_M_LISTEN} owcs_call_state_type;
  typedef enum logic [1:0] {OWCS_L_OFF, OWCS_L_SLEEP, OWCS_L_WIN, OWCS_L_DET} owcs_listen_state_type;
  typedef enum logic [2:0] {OWCS_T_IDLE, OWCS_T_PRE, OWCS_T_ID, OWCS_T_TIME, OWCS_T_LEN,
                            OWCS_T_PAY, OWCS_T_CRCH, OWCS_T_CRCL} owcs_tx_state_type;

  typedef struct packed {
    logic              valid;
    owcs_cmd_code_type code;
  } owcs_cmd_type;

  typedef struct packed {
    logic done;
    logic crc_ok;
  } owcs_rx_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } owcs_tx_type;
endpackage

/* owcs_sequencer.sv */
// owcs_sequencer: wakeup call, wakeup listening, post-call receive window,
// first packet framing and automatic acknowledge of the link manager.
// assumes the radio front end gives the ook detector level on an async pin
// and packet results on clk_sys; host access through a simple register port.
`timescale 1ns/10ps
`default_nettype none
module owcs_sequencer
  import owcs_pkg::*;
#(
  parameter int unsigned CALL_BASE  = CALL_BASE_CYC,   // cycles of shortest call
  parameter int unsigned WIN_CYC    = LISTEN_WIN_CYC,  // detect window length
  parameter int unsigned LBASE_CYC  = LISTEN_BASE_CYC, // shortest listen period
  parameter int unsigned FSK_CYC    = FSK_WIN_CYC,     // post-call receive window
  parameter logic [7:0]  CLIENT_ID  = 8'h5C,           // arbitrary value
  parameter logic [7:0]  TIMING_B   = 8'h00            // cycle time and random pointer
) (
  input  wire  logic         clk_sys,
  input  wire  logic         rst_n,
  input  wire  logic         ce,
  input  wire  logic [7:0]   reg_addr,
  input  wire  logic         reg_wr,
  input  wire  logic         reg_rd,
  input  wire  logic [7:0]   reg_wdata,
  output logic       [7:0]   reg_rdata,
  input  wire  owcs_cmd_type cmd,
  input  wire  logic         ook_pin,
  input  wire  owcs_rx_type  rx_pkt,
  input  wire  logic         tx_ready,
  output owcs_tx_type        tx_out,
  output logic               carrier_gate,
  output logic               ook_rx_window,
  output logic               fsk_rx_on,
  output logic               timer_comm_suspend,
  output logic               ack_start,
  output logic               irq
);
  // register file
  logic [7:0] mode_ctrl_r;                 // 0x00
  logic [7:0] scan_ctrl_r;                 // 0x03
  logic [7:0] wake_ctrl_r;                 // 0x04
  logic [7:0] mask_r;                      // 0x2C
  logic [7:0] len_r;                       // 0x37
  logic [7:0] rx_count_r;                  // accepted packets
  logic       alert_flag_r;                // sticky alert event
  logic [7:0] pay_mem [PAY_DEPTH];         // payload buffer
  // state
  owcs_call_state_type   call_st_r;
  owcs_listen_state_type lst_r;
  owcs_tx_state_type     tx_st_r;
  logic [31:0] call_cnt_r;                 // call and fsk window timer
  logic [9:0]  half_cnt_r;                 // ook half period
  logic [31:0] per_cnt_r;                  // listen period position
  logic [31:0] act_cnt_r;                  // activity time while detecting
  logic [4:0]  pay_idx_r;
  logic [15:0] crc_r;
  logic        ook_s1_r, ook_s2_r, ook_s3_r, ook_lvl_r;

  // crc16 ccitt over one byte
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      x = x[15] ? ((x << 1) ^ CRC_POLY) : (x << 1);
    end
    return x;
  endfunction

  // decode and selection
  wire        wr_hit     = ce & reg_wr;
  wire        rd_stat    = ce & reg_rd & (reg_addr == ADDR_EVT_STATUS);
  wire        pay_hit    = (reg_addr >= ADDR_PAY_FIRST) && (reg_addr <= ADDR_PAY_LAST);
  wire [4:0]  pay_waddr  = 5'(reg_addr - ADDR_PAY_FIRST);
  wire        call_hold  = wake_ctrl_r[BIT_CALL_HOLD];
  wire        scan_hold  = scan_ctrl_r[BIT_LISTEN_HOLD];
  wire        listen_en  = mode_ctrl_r[BIT_LISTEN_EN];
  wire [31:0] call_dur   = CALL_BASE << wake_ctrl_r[1:0];
  wire [31:0] lper       = LBASE_CYC << wake_ctrl_r[LSB_LISTEN_SEL +: 3];
  wire [31:0] act_lim    = 32'(ACT_PERIODS) * lper;
  wire        cmd_call   = cmd.valid && (cmd.code == OWCS_CMD_CALL);
  wire        cmd_listen = cmd.valid && (cmd.code == OWCS_CMD_LISTEN);
  wire        cmd_tx     = cmd.valid && (cmd.code == OWCS_CMD_TRANSMIT);
  wire        call_done  = (call_cnt_r >= call_dur - 32'd1);
  wire        fsk_done   = (call_cnt_r >= FSK_CYC - 32'd1);
  wire        rx_good    = rx_pkt.done & rx_pkt.crc_ok;
  wire        act_out    = (act_cnt_r >= act_lim);
  wire        det_drop   = (lst_r == OWCS_L_DET) && !ook_lvl_r;
  wire        tx_take    = tx_out.valid & tx_ready;
  wire [15:0] crc_nxt    = crc_step(crc_r, tx_out.data);                   // crc with the byte on the link
  wire [4:0]  len_eff    = (len_r[4:0] > 5'(PAY_DEPTH)) ? 5'(PAY_DEPTH) : len_r[4:0];
  wire [7:0]  rd_mux     = (reg_addr == ADDR_MODE_CTRL)  ? mode_ctrl_r :
                           (reg_addr == ADDR_SCAN_CTRL)  ? scan_ctrl_r :
                           (reg_addr == ADDR_WAKE_CTRL)  ? wake_ctrl_r :
                           (reg_addr == ADDR_EVT_MASK)   ? mask_r :
                           (reg_addr == ADDR_PAY_LEN)    ? len_r :
                           (reg_addr == ADDR_RX_COUNT)   ? rx_count_r :
                           (reg_addr == ADDR_EVT_STATUS) ? 8'(alert_flag_r) << BIT_ALERT :
                           pay_hit ? pay_mem[pay_waddr] : 8'h00;

  // control registers; the listen command sets the enable bit itself
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_ctrl_r <= RST_REG8;
      scan_ctrl_r <= RST_REG8;
      wake_ctrl_r <= RST_REG8;
      mask_r      <= RST_REG8;
      len_r       <= RST_REG8;
    end else if (ce) begin
      if (reg_wr && reg_addr == ADDR_MODE_CTRL) mode_ctrl_r <= reg_wdata;
      else if (cmd_listen) mode_ctrl_r[BIT_LISTEN_EN] <= 1'b1;
      if (reg_wr && reg_addr == ADDR_SCAN_CTRL) scan_ctrl_r <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_WAKE_CTRL) wake_ctrl_r <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_EVT_MASK) mask_r <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_PAY_LEN) len_r <= reg_wdata;
    end
  end

  // payload buffer, one byte per address
  always_ff @(posedge clk_sys) begin
    if (wr_hit && pay_hit) pay_mem[pay_waddr] <= reg_wdata;
  end

  // read data stands until the next read strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_n) reg_rdata <= 8'h00;
    else if (ce && reg_rd) reg_rdata <= rd_mux;
  end

  // ook pin synchroniser; level moves only when stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ook_s1_r  <= 1'b0;
      ook_s2_r  <= 1'b0;
      ook_s3_r  <= 1'b0;
      ook_lvl_r <= 1'b0;
    end else if (ce) begin
      ook_s1_r <= ook_pin;
      ook_s2_r <= ook_s1_r;
      ook_s3_r <= ook_s2_r;
      if (ook_s2_r == ook_s3_r) ook_lvl_r <= ook_s3_r;
    end
  end

  // master side: call, then receive window
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      call_st_r  <= OWCS_M_IDLE;
      call_cnt_r <= 32'd0;
    end else if (ce) begin
      case (call_st_r)
        OWCS_M_IDLE: begin
          call_cnt_r <= 32'd0;
          if (cmd_call) call_st_r <= OWCS_M_CALL;
        end
        OWCS_M_CALL: begin
          // hold overrides the timer; releasing it ends the call at once
          // pinned at full count, so the first cycle without hold ends the call
          if (call_hold) call_cnt_r <= '1;
          else if (call_done) begin
            call_st_r  <= OWCS_M_LISTEN;
            call_cnt_r <= 32'd0;
          end else call_cnt_r <= call_cnt_r + 32'd1;
        end
        OWCS_M_LISTEN: begin
          if (scan_hold) call_cnt_r <= 32'd0;
          else if (fsk_done) call_st_r <= OWCS_M_IDLE;
          else call_cnt_r <= call_cnt_r + 32'd1;
        end
        default: call_st_r <= OWCS_M_IDLE;
      endcase
    end
  end

  // ook keying of the carrier during the call
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      half_cnt_r   <= 10'd0;
      carrier_gate <= 1'b0;
    end else if (ce) begin
      if (call_st_r != OWCS_M_CALL) begin
        half_cnt_r   <= 10'd0;
        carrier_gate <= 1'b0;
      end else if (half_cnt_r == 10'(OOK_HALF_CYC - 1)) begin
        half_cnt_r   <= 10'd0;
        carrier_gate <= ~carrier_gate;
      end else half_cnt_r <= half_cnt_r + 10'd1;
    end
  end

  // receiver on and timers parked while the window is open; both from flops
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fsk_rx_on          <= 1'b0;
      timer_comm_suspend <= 1'b0;
    end else if (ce) begin
      fsk_rx_on          <= (call_st_r == OWCS_M_LISTEN);
      timer_comm_suspend <= (call_st_r == OWCS_M_LISTEN);
    end
  end

  // client side: periodic sampling and detection
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lst_r     <= OWCS_L_OFF;
      per_cnt_r <= 32'd0;
      act_cnt_r <= 32'd0;
    end else if (ce) begin
      per_cnt_r <= (per_cnt_r >= lper - 32'd1) ? 32'd0 : per_cnt_r + 32'd1;
      case (lst_r)
        OWCS_L_OFF: begin
          per_cnt_r <= 32'd0;
          if (listen_en) lst_r <= OWCS_L_WIN;
        end
        OWCS_L_SLEEP: if (per_cnt_r >= lper - 32'd1) lst_r <= OWCS_L_WIN;
        OWCS_L_WIN: begin
          act_cnt_r <= 32'd0;
          if (ook_lvl_r) lst_r <= OWCS_L_DET;
          else if (per_cnt_r >= WIN_CYC - 32'd1) lst_r <= OWCS_L_SLEEP;
        end
        OWCS_L_DET: begin
          act_cnt_r <= act_cnt_r + 32'd1;
          if (det_drop || act_out) begin
            lst_r     <= OWCS_L_SLEEP;
            per_cnt_r <= 32'd0;
          end
        end
        default: lst_r <= OWCS_L_OFF;
      endcase
      if (!listen_en) lst_r <= OWCS_L_OFF;
    end
  end

  // window output follows sampling state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) ook_rx_window <= 1'b0;
    else if (ce) ook_rx_window <= (lst_r == OWCS_L_WIN) || (lst_r == OWCS_L_DET);
  end

  // sticky alert; a new alert beats a clearing read in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) alert_flag_r <= 1'b0;
    else if (ce) begin
      if (det_drop) alert_flag_r <= 1'b1;
      else if (rd_stat) alert_flag_r <= 1'b0;
    end
  end

  // interrupt line, masked alert only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) irq <= 1'b0;
    else if (ce) irq <= alert_flag_r & ~mask_r[BIT_ALERT];
  end

  // every good packet gets an ack, whichever client sent it; counted only while the receive window is open
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_start  <= 1'b0;
      rx_count_r <= 8'h00;
    end else if (ce) begin
      ack_start <= rx_good;
      if (rx_good && call_st_r == OWCS_M_LISTEN) rx_count_r <= rx_count_r + 8'h01;
    end
  end

  // first packet framing; crc covers id through payload
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_st_r   <= OWCS_T_IDLE;
      tx_out    <= '0;
      pay_idx_r <= 5'd0;
      crc_r     <= CRC_INIT;
    end else if (ce) begin
      case (tx_st_r)
        OWCS_T_IDLE: if (cmd_tx) begin
          tx_st_r <= OWCS_T_PRE;
          tx_out  <= '{valid: 1'b1, data: PREAMBLE_BYTE};
          crc_r   <= CRC_INIT;
        end
        OWCS_T_PRE: if (tx_take) begin
          tx_st_r     <= OWCS_T_ID;
          tx_out.data <= CLIENT_ID;
        end
        OWCS_T_ID: if (tx_take) begin
          tx_st_r     <= OWCS_T_TIME;
          tx_out.data <= TIMING_B;
          crc_r       <= crc_step(crc_r, tx_out.data);
        end
        OWCS_T_TIME: if (tx_take) begin
          tx_st_r     <= OWCS_T_LEN;
          tx_out.data <= {3'b000, len_eff};
          crc_r       <= crc_step(crc_r, tx_out.data);
        end
        OWCS_T_LEN, OWCS_T_PAY: if (tx_take) begin
          // empty payload skips straight to the crc
          if (pay_idx_r == len_eff) begin
            tx_st_r     <= OWCS_T_CRCH;
            tx_out.data <= crc_nxt[15:8];
          end else begin
            tx_st_r     <= OWCS_T_PAY;
            tx_out.data <= pay_mem[pay_idx_r];
            pay_idx_r   <= pay_idx_r + 5'd1;
          end
          crc_r <= crc_step(crc_r, tx_out.data);
        end
        OWCS_T_CRCH: if (tx_take) begin
          tx_st_r     <= OWCS_T_CRCL;
          tx_out.data <= crc_r[7:0];
        end
        OWCS_T_CRCL: if (tx_take) begin
          tx_st_r   <= OWCS_T_IDLE;
          tx_out    <= '0;
          pay_idx_r <= 5'd0;
        end
        default: tx_st_r <= OWCS_T_IDLE;
      endcase
    end
  end

  // checks
  sequence s_pre_taken;
    ce && tx_st_r == OWCS_T_PRE && tx_ready;
  endsequence
  property p_pkt_order;
    @(posedge clk_sys) disable iff (!rst_n) s_pre_taken |=> (tx_st_r == OWCS_T_ID) && (tx_out.data == CLIENT_ID);
  endproperty
  a_pkt_order: assert property (p_pkt_order) else $error("preamble not followed by id");
  property p_gate_idle;
    @(posedge clk_sys) disable iff (!rst_n) (ce && call_st_r != OWCS_M_CALL) |=> !carrier_gate;
  endproperty
  a_gate_idle: assert property (p_gate_idle) else $error("carrier keyed outside call");
  property p_gate_half;
    @(posedge clk_sys) disable iff (!rst_n)
      (ce && call_st_r == OWCS_M_CALL && half_cnt_r != 10'(OOK_HALF_CYC - 1)) |=> $stable(carrier_gate);
  endproperty
  a_gate_half: assert property (p_gate_half) else $error("carrier toggled early");
  property p_hold_call;
    @(posedge clk_sys) disable iff (!rst_n) (ce && call_st_r == OWCS_M_CALL && call_hold) |=> call_st_r == OWCS_M_CALL;
  endproperty
  a_hold_call: assert property (p_hold_call) else $error("held call ended");
  property p_call_end;
    @(posedge clk_sys) disable iff (!rst_n)
      (ce && call_st_r == OWCS_M_CALL && !call_hold && call_done) |=> call_st_r == OWCS_M_LISTEN ##1 fsk_rx_on || !ce;
  endproperty
  a_call_end: assert property (p_call_end) else $error("no receive window after call");
  property p_scan_hold;
    @(posedge clk_sys) disable iff (!rst_n) (ce && call_st_r == OWCS_M_LISTEN && scan_hold) |=> call_st_r == OWCS_M_LISTEN;
  endproperty
  a_scan_hold: assert property (p_scan_hold) else $error("held window closed");
  property p_suspend;
    @(posedge clk_sys) disable iff (!rst_n) fsk_rx_on |-> timer_comm_suspend;
  endproperty
  a_suspend: assert property (p_suspend) else $error("timers run during window");
  property p_alert_drop;
    @(posedge clk_sys) disable iff (!rst_n) (ce && det_drop) |=> alert_flag_r && lst_r != OWCS_L_DET;
  endproperty
  a_alert_drop: assert property (p_alert_drop) else $error("pattern end did not raise alert");
  property p_no_alert_tmo;
    @(posedge clk_sys) disable iff (!rst_n)
      (ce && lst_r == OWCS_L_DET && ook_lvl_r && act_out && !alert_flag_r) |=> !alert_flag_r;
  endproperty
  a_no_alert_tmo: assert property (p_no_alert_tmo) else $error("timeout raised alert");
  property p_irq_mask;
    @(posedge clk_sys) disable iff (!rst_n) (ce && mask_r[BIT_ALERT]) |=> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked alert on irq");
  property p_ack;
    @(posedge clk_sys) disable iff (!rst_n) (ce && rx_good) |=> ack_start;
  endproperty
  a_ack: assert property (p_ack) else $error("good packet not acknowledged");
endmodule
`default_nettype wire

/* owcs_radio_model.sv */
// owcs_radio_model: radio side of the sequencer (ook level, packet results, byte acceptance)
// assumes the bench calls its tasks from a process that drives on falling edges
`timescale 1ns/10ps
`default_nettype none
module owcs_radio_model
  import owcs_pkg::*;
(
  input  wire logic   clk_sys,
  output logic        ook_pin,
  output owcs_rx_type rx_pkt,
  output logic        tx_ready
);
  logic slow = 1'b0; // ready only every other cycle when set
  logic ph   = 1'b0; // stall phase
  initial ook_pin = 1'b0;
  initial rx_pkt = '0;
  // phase moves after the taking edge, so the bench never samples it mid-change
  always @(posedge clk_sys) begin
    ph <= ~ph;
  end
  assign tx_ready = ~slow | ph;
  // detector level seen by the wakeup receiver
  task automatic ook(input logic lv);
    @(negedge clk_sys);
    ook_pin = lv;
  endtask
  // one finished packet from some client; done lasts one cycle
  task automatic pkt(input logic ok);
    @(negedge clk_sys);
    rx_pkt = '{done: 1'b1, crc_ok: ok};
    @(negedge clk_sys);
    rx_pkt = '{done: 1'b0, crc_ok: 1'b0};
  endtask
endmodule
`default_nettype wire

/* test_ook_wakeup_call_sequencer.sv */
// test_ook_wakeup_call_sequencer: register, call, listen, receive and transmit checks
// assumes shortened timing parameters; inputs change on falling edges, except tx_ready, which moves just after rising edges
`timescale 1ns/10ps
`default_nettype none
module test_ook_wakeup_call_sequencer;
  import owcs_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, lv;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  owcs_cmd_type cmd = '{valid: 1'b0, code: OWCS_CMD_NONE};
  owcs_rx_type rx_pkt;
  owcs_tx_type tx_out;
  logic ook_pin, tx_ready, carrier_gate, ook_rx_window, fsk_rx_on, timer_comm_suspend, ack_start, irq;
  int error_cnt = 0, compares = 0, cyc = 0, n, k;
  logic [7:0] q[$], ex[$];
  logic [15:0] crc;
  // id and timing byte stay at their defaults, only the timers are shortened
  owcs_sequencer #(.CALL_BASE(40), .WIN_CYC(8), .LBASE_CYC(64), .FSK_CYC(50))
    i_owcs_sequencer (.clk_sys(clk_sys), .rst_n(rst_n),
    .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .cmd(cmd), .ook_pin(ook_pin), .rx_pkt(rx_pkt), .tx_ready(tx_ready),
    .tx_out(tx_out), .carrier_gate(carrier_gate), .ook_rx_window(ook_rx_window),
    .fsk_rx_on(fsk_rx_on), .timer_comm_suspend(timer_comm_suspend), .ack_start(ack_start), .irq(irq));
  owcs_radio_model i_owcs_radio_model (.clk_sys(clk_sys), .ook_pin(ook_pin), .rx_pkt(rx_pkt),
    .tx_ready(tx_ready));
  always #5 clk_sys = ~clk_sys;
  // compare helper, counts every check
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  // register read, data registered one cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk("reg", {a, e}, {a, reg_rdata});
  endtask
  // one-cycle command pulse
  task automatic go(input owcs_cmd_code_type c);
    @(negedge clk_sys);
    cmd = '{valid: 1'b1, code: c};
    @(negedge clk_sys);
    cmd.valid = 1'b0;
  endtask
  // independent crc, msb first
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {b[i], 8'h00};
      repeat (8) c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
    end
    return c;
  endfunction
  task automatic print_verdict;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // hang guard, run needs well under this
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    for (k = 0; k < 5; k++) rd(k[1] ? 8'h2C : 8'h00 + 8'(k), 8'h00); // register reset values
    wr(8'hFF, 8'h5A);
    rd(8'hFF, 8'h00);
    // timed call for every length code, window and suspend follow
    for (k = 0; k < 4; k++) begin
      wr(ADDR_WAKE_CTRL, 8'(k));
      go(OWCS_CMD_CALL);
      for (n = 0; n < 2000 && fsk_rx_on !== 1'b1; n++) @(negedge clk_sys);
      chk("call len", 1, n >= (40 << k) - 1 && n <= (40 << k) + 4);
      for (n = 0; n < 500 && fsk_rx_on === 1'b1; n++) begin
        chk("suspend", 1, timer_comm_suspend);
        @(negedge clk_sys);
      end
      chk("window", 1, n >= 49 && n <= 51);
    end
    // held call keys the carrier until release, then a held window
    wr(ADDR_WAKE_CTRL, 8'h20);
    go(OWCS_CMD_CALL);
    k = 0;
    lv = carrier_gate;
    repeat (1100) begin
      @(negedge clk_sys);
      k += (carrier_gate !== lv);
      lv = carrier_gate;
    end
    chk("ook toggles", 2, k);
    chk("fsk in hold", 0, fsk_rx_on);
    // clock enable low: the next carrier toggle must not come
    ce = 1'b0;
    lv = carrier_gate;
    repeat (600) @(negedge clk_sys);
    chk("ce freeze", lv, carrier_gate);
    ce = 1'b1;
    wr(ADDR_SCAN_CTRL, 8'h40);
    wr(ADDR_WAKE_CTRL, 8'h00);
    for (n = 0; n < 8 && fsk_rx_on !== 1'b1; n++) @(negedge clk_sys);
    chk("release", 1, fsk_rx_on);
    for (lv = 1'b1; lv !== 1'b0; lv = 1'b0) begin
      for (k = 0; k < 3; k++) begin
        i_owcs_radio_model.pkt(k < 2);
        n = 0;
        repeat (4) begin
          n += (ack_start === 1'b1);
          @(negedge clk_sys);
        end
        chk("ack", k < 2, n);
      end
    end
    repeat (60) @(negedge clk_sys);
    chk("held fsk", 1, fsk_rx_on);
    rd(ADDR_RX_COUNT, 8'h02);
    wr(ADDR_SCAN_CTRL, 8'h00);
    for (n = 0; n < 100 && fsk_rx_on !== 1'b0; n++) @(negedge clk_sys);
    chk("fsk end", 0, fsk_rx_on);
    // listening: window width, alert with and without mask
    go(OWCS_CMD_LISTEN);
    rd(ADDR_MODE_CTRL, 8'h04);
    repeat (10) @(negedge clk_sys);
    n = 0;
    repeat (64) begin
      n += (ook_rx_window === 1'b1);
      @(negedge clk_sys);
    end
    chk("listen win", 8, n);
    for (k = 0; k < 3; k++) begin
      wr(ADDR_EVT_MASK, k == 1 ? 8'h20 : 8'h00);
      // pattern raised while the window is shut, so the next window catches it
      for (n = 0; n < 80 && ook_rx_window !== 1'b0; n++) @(negedge clk_sys);
      i_owcs_radio_model.ook(1'b1);
      for (n = 0; n < 80 && ook_rx_window !== 1'b1; n++) @(negedge clk_sys);
      // first two runs drop the pattern after 40 cycles, the last one times out
      for (n = 0; n < (k == 2 ? 400 : 40) && ook_rx_window === 1'b1; n++) @(negedge clk_sys);
      chk("detect held", 1, k == 2 ? (n > 3 * 64 && n < 3 * 64 + 16) : (n == 40));
      i_owcs_radio_model.ook(1'b0);
      repeat (12) @(negedge clk_sys);
      chk("irq", k == 0, irq);
      rd(ADDR_EVT_STATUS, k == 2 ? 8'h00 : 8'h20);
    end
    wr(ADDR_MODE_CTRL, 8'h00);
    // first packet: length, payload, then transmit with a slow radio
    wr(ADDR_PAY_LEN, 8'h1F);
    rd(ADDR_PAY_LEN, 8'h1F);
    wr(ADDR_PAY_LEN, 8'h02);
    wr(ADDR_PAY_FIRST, 8'h11);
    wr(8'h39, 8'h22);
    repeat (37) @(negedge clk_sys);
    i_owcs_radio_model.slow = 1'b1;
    ex = '{8'h5C, 8'h00, 8'h02, 8'h11, 8'h22};
    crc = crc16(ex);
    ex = '{8'hAA, 8'h5C, 8'h00, 8'h02, 8'h11, 8'h22, crc[15:8], crc[7:0]};
    go(OWCS_CMD_TRANSMIT);
    for (n = 0; n < 60; n++) begin
      if (tx_out.valid === 1'b1 && tx_ready === 1'b1) q.push_back(tx_out.data);
      @(negedge clk_sys);
    end
    chk("bytes", 8, q.size());
    foreach (ex[i]) chk("byte", ex[i], i < q.size() ? q[i] : 8'h00);
    chk("tx idle", 0, tx_out.valid);
    print_verdict();
  end
endmodule
`default_nettype wire
